// ==== design/vac_pkg.sv ====
// Package: port map, field layout and carriers for the video control register bank
package vac_pkg;
  // Port addresses
  localparam logic [15:0] CRTC_INDEX_PORT  = 16'h03D4;
  localparam logic [15:0] CRTC_VALUE_PORT  = 16'h03D5;
  localparam logic [15:0] MODE_SELECT_PORT = 16'h03D8;
  localparam logic [15:0] COLOR_SEL_PORT   = 16'h03D9;
  localparam logic [15:0] ARRAY_INDEX_PORT = 16'h03DA;
  localparam logic [15:0] PEN_CLEAR_PORT   = 16'h03DB;
  localparam logic [15:0] PEN_PRESET_PORT  = 16'h03DC;
  localparam logic [15:0] EXT_PAGE_PORT    = 16'h03DD;
  localparam logic [15:0] ARRAY_VALUE_PORT = 16'h03DE;
  localparam logic [15:0] PAGE_PORT        = 16'h03DF;
  localparam logic [15:0] MONO_MODE_PORT   = 16'h03B8;
  localparam logic [15:0] MONO_STAT_PORT   = 16'h03BA;
  localparam logic [15:0] CONFIG_PORT_LO   = 16'h00A0;
  localparam logic [15:0] CONFIG_PORT_HI   = 16'h00A7;
  // Config register field
  localparam int          CFG_EXT_VIDEO_BIT = 0;
  // Array indexes
  localparam logic [4:0]  IDX_PAL_MASK   = 5'h01;
  localparam logic [4:0]  IDX_BORDER     = 5'h02;
  localparam logic [4:0]  IDX_MODE_CTRL  = 5'h03;
  localparam logic [4:0]  IDX_PAL_BASE   = 5'h10;
  localparam int          PAL_ENTRIES    = 16;
  // Reset values
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [3:0]  RST_NIBBLE     = 4'h0;
  localparam logic [5:0]  RST_SIX        = 6'h00;

  // Host I/O cycle
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vac_io_s;

  // Live display status inputs
  typedef struct packed {
    logic disp_inactive;
    logic pen_trigger;
    logic pen_switch;
    logic vretrace;
  } vac_stat_s;
endpackage : vac_pkg

// ==== design/vac_regs.sv ====
// Video control register bank reached over the host I/O port bus
`timescale 1ns/100ps
module vac_regs #(
  parameter int PAL_N = vac_pkg::PAL_ENTRIES
) (
  input  wire logic                I_SYS_CLK,
  input  wire logic                I_RST,
  input  wire vac_pkg::vac_io_s    I_IO,
  input  wire vac_pkg::vac_stat_s  I_STAT,
  input  wire logic [7:0]          I_CRTC_RDATA,
  output logic [7:0]               O_RDATA,
  output logic                     O_RDATA_EN,
  output logic                     O_CRTC_SEL,
  output logic                     O_CRTC_RS,
  output logic                     O_CRTC_WR,
  output logic [7:0]               O_CRTC_WDATA,
  output logic                     O_MONO_DECODE,
  output logic                     O_VIDEO_ON,
  output logic                     O_HIRES_TEXT,
  output logic                     O_GFX_320,
  output logic                     O_BW,
  output logic                     O_GFX_640,
  output logic                     O_BLINK,
  output logic [5:0]               O_COLOR_SEL,
  output logic [3:0]               O_PAL_MASK,
  output logic [3:0]               O_BORDER,
  output logic [5:0]               O_ARRAY_MODE,
  output logic [7:0]               O_EXT_PAGE,
  output logic [7:0]               O_PAGE,
  output logic [PAL_N*4-1:0]       O_PALETTE,
  output logic                     O_PEN_LATCH
);
  import vac_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin status synchronisers: three stages, change taken when 2 and 3 agree
  logic [3:0] st_s1;
  logic [3:0] st_s2;
  logic [3:0] st_s3;
  logic [3:0] st_q;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_s1 <= RST_NIBBLE;
      st_s2 <= RST_NIBBLE;
      st_s3 <= RST_NIBBLE;
      st_q  <= RST_NIBBLE;
    end else begin
      st_s1 <= {I_STAT.disp_inactive, I_STAT.pen_trigger, I_STAT.pen_switch,
                I_STAT.vretrace};
      st_s2 <= st_s1;
      st_s3 <= st_s2;
      st_q  <= (st_s2 & st_s3) | (st_q & (st_s2 | st_s3));
    end
  end
  logic pen_trig_prev;
  logic pen_rise;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) pen_trig_prev <= 1'b0;
    else       pen_trig_prev <= st_q[2];
  end
  assign pen_rise = st_q[2] & ~pen_trig_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Decode; external video removes every on-board port except the config one and, with mono enable set, the mono ones
  logic       ext_video;
  logic       hit_cfg;
  logic       vid_ok;
  logic       wr;
  logic       rd;
  logic [15:0] a;
  assign a         = I_IO.addr;
  assign wr        = I_IO.wr;
  assign rd        = I_IO.rd;
  assign hit_cfg   = (a >= CONFIG_PORT_LO) && (a <= CONFIG_PORT_HI);
  assign vid_ok    = ~ext_video;

  // Config port is write only; only its external video bit matters to our decode
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST)              ext_video <= 1'b0;
    else if (wr && hit_cfg) ext_video <= I_IO.wdata[CFG_EXT_VIDEO_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Directly addressed registers
  logic [7:0] mode_sel;
  logic [7:0] color_sel;
  logic [7:0] ext_page;
  logic [7:0] page;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode_sel  <= RST_BYTE;
      color_sel <= RST_BYTE;
      ext_page  <= RST_BYTE;
      page      <= RST_BYTE;
    end else if (wr && vid_ok) begin
      if (a == MODE_SELECT_PORT) mode_sel  <= I_IO.wdata;
      if (a == COLOR_SEL_PORT)   color_sel <= I_IO.wdata;
      if (a == EXT_PAGE_PORT)    ext_page  <= I_IO.wdata;
      if (a == PAGE_PORT)        page      <= I_IO.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array index, held until the next index write
  logic [4:0] arr_idx;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) arr_idx <= 5'h00;
    else if (wr && vid_ok && a == ARRAY_INDEX_PORT) arr_idx <= I_IO.wdata[4:0];
  end
  logic arr_wr;
  assign arr_wr = wr && vid_ok && (a == ARRAY_VALUE_PORT);

  // Array control registers; unused bits are not stored
  logic [3:0] pal_mask;
  logic [3:0] border;
  logic [5:0] arr_mode;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      pal_mask <= RST_NIBBLE;
      border   <= RST_NIBBLE;
      arr_mode <= RST_SIX;
    end else if (arr_wr) begin
      if (arr_idx == IDX_PAL_MASK)  pal_mask <= I_IO.wdata[3:0];
      if (arr_idx == IDX_BORDER)    border   <= I_IO.wdata[3:0];
      if (arr_idx == IDX_MODE_CTRL) arr_mode <= {I_IO.wdata[5:2], 1'b0, I_IO.wdata[0]};
    end
  end

  // Palette entries, one per generated slot
  logic [3:0] pal [PAL_N];
  for (genvar g = 0; g < PAL_N; g++) begin : g_pal
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) pal[g] <= RST_NIBBLE;
      else if (arr_wr && arr_idx == IDX_PAL_BASE + 5'(g)) pal[g] <= I_IO.wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Light pen latch: a trigger edge sets it and wins over a clear
  logic pen_latch;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) pen_latch <= 1'b0;
    else if (pen_rise) pen_latch <= 1'b1;
    else if (wr && vid_ok && a == PEN_PRESET_PORT) pen_latch <= 1'b1;
    else if (wr && vid_ok && a == PEN_CLEAR_PORT)  pen_latch <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing controller pass-through: strobes registered one cycle
  logic crtc_hit;
  assign crtc_hit = vid_ok && (a == CRTC_INDEX_PORT || a == CRTC_VALUE_PORT);
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CRTC_SEL   <= 1'b0;
      O_CRTC_RS    <= 1'b0;
      O_CRTC_WR    <= 1'b0;
      O_CRTC_WDATA <= RST_BYTE;
    end else begin
      O_CRTC_SEL   <= crtc_hit && (rd || wr);
      O_CRTC_RS    <= a[0];
      O_CRTC_WR    <= crtc_hit && wr;
      O_CRTC_WDATA <= I_IO.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: one-cycle latency; write-only ports and unused ports stay silent
  logic [7:0] next_rdata;
  logic       next_rdata_en;
  always_comb begin
    next_rdata    = RST_BYTE;
    next_rdata_en = 1'b0;
    if (rd && vid_ok) begin
      next_rdata_en = 1'b1;
      unique case (a)
        CRTC_INDEX_PORT,
        CRTC_VALUE_PORT:  next_rdata = I_CRTC_RDATA;
        MODE_SELECT_PORT: next_rdata = mode_sel;
        COLOR_SEL_PORT:   next_rdata = color_sel;
        ARRAY_INDEX_PORT: next_rdata = {4'h0, st_q[0], st_q[1], pen_latch, st_q[3]};
        EXT_PAGE_PORT:    next_rdata = ext_page;
        PAGE_PORT:        next_rdata = page;
        default:          next_rdata_en = 1'b0;
      endcase
    end
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_RDATA    <= RST_BYTE;
      O_RDATA_EN <= 1'b0;
    end else begin
      O_RDATA    <= next_rdata;
      O_RDATA_EN <= next_rdata_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered control outputs to the display engine
  logic [PAL_N*4-1:0] pal_flat;
  for (genvar g = 0; g < PAL_N; g++) begin : g_flat
    assign pal_flat[g*4 +: 4] = pal[g];
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MONO_DECODE <= 1'b1;
      O_VIDEO_ON    <= 1'b0;
      O_HIRES_TEXT  <= 1'b0;
      O_GFX_320     <= 1'b0;
      O_BW          <= 1'b0;
      O_GFX_640     <= 1'b0;
      O_BLINK       <= 1'b0;
      O_COLOR_SEL   <= RST_SIX;
      O_PAL_MASK    <= RST_NIBBLE;
      O_BORDER      <= RST_NIBBLE;
      O_ARRAY_MODE  <= RST_SIX;
      O_EXT_PAGE    <= RST_BYTE;
      O_PAGE        <= RST_BYTE;
      O_PALETTE     <= '0;
      O_PEN_LATCH   <= 1'b0;
    end else begin
      O_MONO_DECODE <= ~(ext_video & ~arr_mode[0]);
      O_VIDEO_ON    <= mode_sel[3] & vid_ok;
      O_HIRES_TEXT  <= mode_sel[0];
      O_GFX_320     <= mode_sel[1];
      O_BW          <= mode_sel[2];
      O_GFX_640     <= mode_sel[4];
      O_BLINK       <= mode_sel[5];
      O_COLOR_SEL   <= color_sel[5:0];
      O_PAL_MASK    <= pal_mask;
      O_BORDER      <= border;
      O_ARRAY_MODE  <= arr_mode;
      O_EXT_PAGE    <= ext_page;
      O_PAGE        <= page;
      O_PALETTE     <= pal_flat;
      O_PEN_LATCH   <= pen_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_idx_wr(logic [4:0] v);
    wr && vid_ok && a == ARRAY_INDEX_PORT && I_IO.wdata[4:0] == v;
  endsequence

  a_mode_bits: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && vid_ok && a == MODE_SELECT_PORT |=> ##1 O_HIRES_TEXT == $past(I_IO.wdata[0], 2))
    else $error("mode bit 0 not reflected");
  a_gfx_320: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_GFX_320 == $past(mode_sel[1])) else $error("graphics select wrong");
  a_bw_out: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_BW == $past(mode_sel[2])) else $error("bw select wrong");
  a_video_gate: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !mode_sel[3] |=> !O_VIDEO_ON) else $error("video not blanked");
  a_gfx_640: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_GFX_640 == $past(mode_sel[4])) else $error("640 mode wrong");
  a_blink_on: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_BLINK == $past(mode_sel[5])) else $error("blink wrong");
  a_index_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_idx_wr(IDX_BORDER) ##1 (!(wr && a == ARRAY_INDEX_PORT))[*2] |=> arr_idx == IDX_BORDER)
    else $error("array index lost");
  a_border_wr: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    arr_wr && arr_idx == IDX_BORDER |=> border == $past(I_IO.wdata[3:0]))
    else $error("border not written");
  a_pen_clear: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && vid_ok && a == PEN_CLEAR_PORT && !pen_rise |=> !pen_latch)
    else $error("pen latch not cleared");
  a_ext_block: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    ext_video && rd |=> !O_RDATA_EN) else $error("read answered while disabled");
  a_mono_off: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    ext_video && !arr_mode[0] |=> !O_MONO_DECODE) else $error("mono decode kept");
  a_status_rd: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    rd && vid_ok && a == ARRAY_INDEX_PORT |=> O_RDATA_EN && O_RDATA[1] == $past(pen_latch))
    else $error("status read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Array accesses in steps: index write, a cycle with no index write, data byte
  sequence s_val_wr;
    arr_wr;
  endsequence
  sequence s_idx_quiet;
    !(wr && a == ARRAY_INDEX_PORT);
  endsequence
  sequence s_mask_access;
    s_idx_wr(IDX_PAL_MASK) ##1 s_idx_quiet ##1 s_val_wr;
  endsequence
  sequence s_mode_access;
    s_idx_wr(IDX_MODE_CTRL) ##1 s_idx_quiet ##1 s_val_wr;
  endsequence

  // Index and array registers capture on the edge after the access
  a_idx_load: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && vid_ok && a == ARRAY_INDEX_PORT |=> arr_idx == $past(I_IO.wdata[4:0]))
    else $error("array index not loaded");
  a_mask_pair: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_mask_access |=> pal_mask == $past(I_IO.wdata[3:0]))
    else $error("palette mask not written");
  a_mask_out: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_PAL_MASK == $past(pal_mask)) else $error("palette mask output wrong");
  a_mode_pair: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    s_mode_access |=> arr_mode == {$past(I_IO.wdata[5:2]), 1'b0, $past(I_IO.wdata[0])})
    else $error("array mode not written");
  a_mode_rsvd: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !arr_mode[1]) else $error("reserved mode bit set");
  a_pal_entry: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    arr_wr && arr_idx[4] |=>
      pal_flat[$past(arr_idx[3:0]) * 4 +: 4] == $past(I_IO.wdata[3:0]))
    else $error("palette entry not written");
  a_border_out: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_BORDER == $past(border)) else $error("border output wrong");

  // Directly addressed registers and their staged outputs
  a_color_wr: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && vid_ok && a == COLOR_SEL_PORT |=> color_sel == $past(I_IO.wdata))
    else $error("color select not written");
  a_color_out: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_COLOR_SEL == $past(color_sel[5:0])) else $error("color output wrong");
  a_hires_out: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    O_HIRES_TEXT == $past(mode_sel[0])) else $error("text width wrong");

  // Page registers: register on the first edge, output on the second
  a_ext_page: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && vid_ok && a == EXT_PAGE_PORT |=> ##1 O_EXT_PAGE == $past(I_IO.wdata, 2))
    else $error("extended page wrong");
  a_page_reg: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && vid_ok && a == PAGE_PORT |=> ##1 O_PAGE == $past(I_IO.wdata, 2))
    else $error("page register wrong");

  // Timing controller strobes follow only its own two ports; the array data port never answers a read
  a_crtc_write: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    crtc_hit && wr |=> O_CRTC_SEL && O_CRTC_WR && O_CRTC_RS == $past(a[0]) &&
      O_CRTC_WDATA == $past(I_IO.wdata)) else $error("controller write lost");
  a_crtc_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !(crtc_hit && (rd || wr)) |=> !O_CRTC_SEL && !O_CRTC_WR) else $error("stray strobe");
  a_arr_wo: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    rd && a == ARRAY_VALUE_PORT |=> !O_RDATA_EN) else $error("data port answered");

  // External video bit: loaded from any config alias, then blocks host writes to our other registers
  a_cfg_load: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && hit_cfg |=> ext_video == $past(I_IO.wdata[CFG_EXT_VIDEO_BIT]))
    else $error("external video bit not loaded");
  a_ext_hold: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    ext_video && wr && a == MODE_SELECT_PORT |=> $stable(mode_sel))
    else $error("write taken while disabled");

  // Pen latch set paths
  a_pen_preset: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr && vid_ok && a == PEN_PRESET_PORT |=> pen_latch)
    else $error("pen latch not preset");
  a_pen_edge: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    pen_rise |=> pen_latch) else $error("pen edge missed");

  // Mono decode kept unless both conditions hold; video passes when enabled
  a_mono_keep: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !(ext_video && !arr_mode[0]) |=> O_MONO_DECODE) else $error("mono decode dropped");
  a_video_pass: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    mode_sel[3] && vid_ok |=> O_VIDEO_ON) else $error("video not passed");

  // Status byte: live bits in their places, upper nibble zero
  a_status_live: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    rd && vid_ok && a == ARRAY_INDEX_PORT |=> O_RDATA[7:4] == 4'h0 &&
      O_RDATA[0] == $past(st_q[3]) && O_RDATA[2] == $past(st_q[1]) &&
      O_RDATA[3] == $past(st_q[0])) else $error("status bits misplaced");
endmodule : vac_regs

// ==== test/vac_host_model.sv ====
// Host processor model issuing one-cycle I/O read and write pulses
`timescale 1ns/100ps
module vac_host_model (
  input  wire logic       i_clk,
  output vac_pkg::vac_io_s o_io
);
  import vac_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Bus idle from time zero
  initial o_io = '0;
  // Drive after a falling edge, hold across one rising edge, then release
  task automatic xfer(input logic is_wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_io = '{rd: !is_wr, wr: is_wr, addr: a, wdata: d};
    @(negedge i_clk);
    // Released lines show the inverse so a stale copy is never trusted
    o_io = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
  // Array access: index first, then the data byte
  task automatic arr_wr(input logic [4:0] idx, input logic [7:0] d);
    xfer(1'b1, ARRAY_INDEX_PORT, {3'h0, idx});
    // Border byte always goes out with bit 5 clear
    xfer(1'b1, ARRAY_VALUE_PORT, (idx == IDX_BORDER) ? (d & 8'hDF) : d);
  endtask : arr_wr
endmodule : vac_host_model

// ==== test/test_video_array_control_regs.sv ====
// Self-checking bench for the video control register bank
`timescale 1ns/100ps
module test_video_array_control_regs;
  import vac_pkg::*;
  logic clk, rst;
  vac_io_s io;
  vac_stat_s stat;
  logic [7:0] crtc_rd, rdata, cwd, d, m;
  logic en, csel, crs, cwr, mono, von, hires, g320, bw, g640, blink, pen;
  logic [5:0] csel_o, amode;
  logic [3:0] pmask, border;
  logic [7:0] xpage, page;
  logic [63:0] pal, exp_pal;
  logic [7:0] exp_q[$];
  logic [15:0] bad[5] = '{16'h03DE, 16'h03DB, 16'h03DC, 16'h03D6, 16'h0123};
  int seed, n_fail, total_checks;
  ////////////////////////////////////////////////////////////////////////////
  // Design and host model
  vac_regs i_vac_regs (.I_SYS_CLK(clk), .I_RST(rst), .I_IO(io), .I_STAT(stat),
    .I_CRTC_RDATA(crtc_rd), .O_RDATA(rdata), .O_RDATA_EN(en), .O_CRTC_SEL(csel),
    .O_CRTC_RS(crs), .O_CRTC_WR(cwr), .O_CRTC_WDATA(cwd), .O_MONO_DECODE(mono),
    .O_VIDEO_ON(von), .O_HIRES_TEXT(hires), .O_GFX_320(g320), .O_BW(bw),
    .O_GFX_640(g640), .O_BLINK(blink), .O_COLOR_SEL(csel_o), .O_PAL_MASK(pmask),
    .O_BORDER(border), .O_ARRAY_MODE(amode), .O_EXT_PAGE(xpage), .O_PAGE(page),
    .O_PALETTE(pal), .O_PEN_LATCH(pen));
  vac_host_model i_vac_host_model (.i_clk(clk), .o_io(io));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 40000);
    n_fail++;
    finish_test();
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // Write, then let the register and output flops settle
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    i_vac_host_model.xfer(1'b1, a, v);
    repeat (2) @(negedge clk);
  endtask : wr
  task automatic aw(input logic [4:0] idx, input logic [7:0] v);
    i_vac_host_model.arr_wr(idx, v);
    repeat (2) @(negedge clk);
  endtask : aw
  // Reads note their expected answer; refused reads note nothing
  task automatic rd(input logic [15:0] a, input logic ok, input logic [7:0] v);
    if (ok) exp_q.push_back(v);
    i_vac_host_model.xfer(1'b0, a, 8'h00);
    repeat (2) @(negedge clk);
  endtask : rd
  // Read monitor: every answer takes the oldest note; an unasked answer fails
  always @(negedge clk) begin
    if (en === 1'b1) begin
      if (exp_q.size() == 0) chk(rdata, 64'hFFFF_FFFF_FFFF_FFFF);
      else chk(rdata, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'h13df;
    rst = 1'b1;
    stat = '0;
    crtc_rd = 8'h00;
    repeat (8) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    chk({mono, pen}, 2'b10);
    foreach (bad[i]) rd(bad[i], 1'b0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      m = 8'($random(seed)) & 8'h3F;
      wr(MODE_SELECT_PORT, m);
      chk({blink, g640, von, bw, g320, hires}, m[5:0]);
      rd(MODE_SELECT_PORT, 1'b1, m);
      d = 8'($random(seed)) & 8'h3F;
      wr(COLOR_SEL_PORT, d);
      chk(csel_o, d[5:0]);
      rd(COLOR_SEL_PORT, 1'b1, d);
      d = 8'($random(seed));
      wr(EXT_PAGE_PORT, d);
      chk(xpage, d);
      rd(EXT_PAGE_PORT, 1'b1, d);
      d = 8'($random(seed));
      wr(PAGE_PORT, d);
      chk(page, d);
      rd(PAGE_PORT, 1'b1, d);
    end
    d = 8'($random(seed));
    aw(IDX_PAL_MASK, d);
    chk(pmask, d[3:0]);
    aw(IDX_BORDER, d);
    chk(border, d[3:0]);
    aw(IDX_MODE_CTRL, d);
    chk(amode, {d[5:2], 1'b0, d[0]});
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      i_vac_host_model.arr_wr(IDX_PAL_BASE + 5'(i), d);
      exp_pal[4*i +: 4] = d[3:0];
    end
    repeat (2) @(negedge clk);
    chk(pal, exp_pal);
    // Index held across a status read and two data writes
    i_vac_host_model.xfer(1'b1, ARRAY_INDEX_PORT, 8'h1F);
    rd(ARRAY_INDEX_PORT, 1'b1, 8'h00);
    i_vac_host_model.xfer(1'b1, ARRAY_VALUE_PORT, 8'h05);
    wr(ARRAY_VALUE_PORT, 8'h0A);
    exp_pal[63:60] = 4'hA;
    aw(5'h04, 8'h03);
    chk(pal, exp_pal);
    // Timing controller pass-through
    crtc_rd = 8'($random(seed));
    d = 8'($random(seed));
    i_vac_host_model.xfer(1'b1, CRTC_INDEX_PORT, d);
    chk({csel, crs, cwr, cwd}, {3'b101, d});
    i_vac_host_model.xfer(1'b1, CRTC_VALUE_PORT, ~d);
    chk({csel, crs, cwr, cwd}, {3'b111, ~d});
    rd(CRTC_VALUE_PORT, 1'b1, crtc_rd);
    // Pen latch preset, clear, and trigger edge; then live status
    wr(PEN_PRESET_PORT, 8'h00);
    chk(pen, 1'b1);
    rd(ARRAY_INDEX_PORT, 1'b1, 8'h02);
    wr(PEN_CLEAR_PORT, 8'h00);
    chk(pen, 1'b0);
    stat.pen_trigger = 1'b1;
    repeat (8) @(negedge clk);
    chk(pen, 1'b1);
    stat = '{disp_inactive: 1'b1, pen_trigger: 1'b0, pen_switch: 1'b1, vretrace: 1'b1};
    wr(PEN_CLEAR_PORT, 8'h00);
    repeat (6) @(negedge clk);
    rd(ARRAY_INDEX_PORT, 1'b1, 8'h0D);
    stat = '0;
    // External video: decode off, mono ports kept only with mono enable set
    aw(IDX_MODE_CTRL, 8'h01);
    wr(CONFIG_PORT_LO + 16'($random(seed) & 7), 8'h01);
    chk(mono, 1'b1);
    wr(MODE_SELECT_PORT, ~m);
    // Mode writes ignored, and the on-board video output is forced off
    chk({blink, g640, von, bw, g320, hires}, {m[5:4], 1'b0, m[2:0]});
    rd(MODE_SELECT_PORT, 1'b0, 8'h00);
    wr(CONFIG_PORT_HI, 8'h00);
    aw(IDX_MODE_CTRL, 8'h00);
    chk(mono, 1'b1);
    wr(16'h00A3, 8'h01);
    chk(mono, 1'b0);
    wr(CONFIG_PORT_LO, 8'h00);
    rd(MODE_SELECT_PORT, 1'b1, m);
    chk(exp_q.size(), 0);
    finish_test();
  end
endmodule : test_video_array_control_regs
